//--- verilog/two_stage_watchdog_timer.sv
// Two-stage watchdog timer with Wishbone register slave
`timescale 1ns/1ps

// How it works
// - 32-bit counter counts down from load value
// - Lock makes configuration writes ignored
// - Zero after enable raises interrupt
// - Enabling counter also enables the interrupt
// - After first timeout reload and keep counting
// - Zero again while pending resets if enabled
// - Interrupt clear reloads counter and resumes
// - Load write while running loads counter now
// - Loading zero raises the interrupt at once
// - Locked: enable, int enable, load unchanged
// - Lock status is readable
// - Raw and masked status read one or zero
// - Interrupt clear drops the interrupt source
// - Load value is readable back
// - Unlock restores configuration write access
// - Reset enable gates second timeout, lock-protected
// - Stall pauses counter during debug halt
// - Current counter value readable anytime
module two_stage_watchdog_timer
(
  input  wire logic        clk,         // 250 MHz system clock
  input  wire logic        rst_b,       // Asynchronous reset, active low
  input  wire logic        wbCyc,       // Wishbone cycle
  input  wire logic        wbStb,       // Wishbone strobe
  input  wire logic        wbWe,        // Wishbone write enable
  input  wire logic [3:0]  wbSel,       // Wishbone byte lanes
  input  wire logic [7:0]  wbAdr,       // Wishbone byte address
  input  wire logic [31:0] wbDatWr,     // Wishbone write data
  output logic      [31:0] wbDatRd,     // Wishbone read data
  output logic             wbAck,       // Wishbone acknowledge
  input  wire logic        dbgHalt,     // Processor halted by debugger
  output logic             irq,         // Watchdog interrupt, masked
  output logic             sysResetOut  // System reset request
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset and pin synchronisation

  logic rstSync_b;
  logic haltSync;

  wdt_rst_sync u_rst_sync
  (
    .clk       (clk),
    .rst_b     (rst_b),
    .rstSync_b (rstSync_b)
  );

  wdt_sync2 u_halt_sync
  (
    .clk     (clk),
    .rst_b   (rstSync_b),
    .asyncIn (dbgHalt),
    .syncOut (haltSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [31:0]           count_r;
  logic [31:0]           countNxt;
  logic [31:0]           load_r;
  logic [31:0]           loadNxt;
  wdt_pkg::cfg_t         cfg_r;
  wdt_pkg::cfg_t         cfgNxt;
  wdt_pkg::state_t       state_r;
  wdt_pkg::state_t       stateNxt;
  logic                  intRaw_r;
  logic                  intRawNxt;
  logic                  lock_r;
  logic                  lockNxt;
  logic                  ackNxt;
  logic [31:0]           datNxt;
  logic                  irqNxt;
  logic                  resetNxt;

  // Decoded events, kept visible for the checks below
  logic                  access;
  logic                  wr;
  logic                  halted;
  logic                  tick;
  logic                  timeout;
  logic                  loadWr;
  logic                  ctrlWr;
  logic                  intClr;
  logic                  intSet;
  logic [31:0]           loadMrg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode and events

  // A request is served once; ack drops in the cycle after it was given
  always_comb
  begin
    access  = wbCyc & wbStb & ~wbAck;
    wr      = access & wbWe;
    halted  = cfg_r.stallEn & haltSync;
    tick    = (state_r == wdt_pkg::ST_RUN) & ~halted;
    timeout = tick & (count_r == wdt_pkg::CNT_ZERO);
    // Configuration writes pass only while unlocked
    loadWr  = wr & ~lock_r & (wbAdr == wdt_pkg::OFS_LOAD);
    ctrlWr  = wr & ~lock_r & (wbAdr == wdt_pkg::OFS_CTRL);
    // Clearing is not configuration, so the lock does not block it
    intClr  = wr & (wbAdr == wdt_pkg::OFS_INTCLR);
    // Byte lanes merge into the held load value
    loadMrg = load_r;
    for (int b = 0; b < wdt_pkg::SEL_W; b++)
    begin
      if (wbSel[b])
      begin
        loadMrg[8*b +: 8] = wbDatWr[8*b +: 8];
      end
    end
    intSet  = (timeout & ~intRaw_r)
            | (loadWr & (loadMrg == wdt_pkg::CNT_ZERO));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next values of counter, configuration and flags

  always_comb
  begin
    countNxt  = count_r;
    loadNxt   = load_r;
    cfgNxt    = cfg_r;
    stateNxt  = state_r;
    lockNxt   = lock_r;
    resetNxt  = sysResetOut;

    // Down counter; a zero reload is handled by the timeout path
    case (state_r)
      wdt_pkg::ST_OFF:
      begin
        countNxt = count_r;
      end
      wdt_pkg::ST_RUN:
      begin
        if (timeout)
        begin
          countNxt = load_r;
          if (intRaw_r && cfg_r.resetEn)
          begin
            stateNxt = wdt_pkg::ST_RESET;
          end
        end
        else if (tick)
        begin
          countNxt = count_r - wdt_pkg::CNT_ONE;
        end
      end
      wdt_pkg::ST_RESET:
      begin
        // Held here until the system reset comes back round
        resetNxt = 1'b1;
      end
      default:
      begin
        stateNxt = wdt_pkg::ST_OFF;
      end
    endcase

    // Clearing restarts the count from the load value
    if (intClr && state_r == wdt_pkg::ST_RUN)
    begin
      countNxt = load_r;
    end

    // New load value goes straight into a running counter
    if (loadWr)
    begin
      loadNxt = loadMrg;
      if (state_r == wdt_pkg::ST_RUN)
      begin
        countNxt = loadMrg;
      end
    end

    // Enable bits are set-only; reset and stall enables follow the write
    if (ctrlWr && wbSel[0])
    begin
      if (wbDatWr[wdt_pkg::CB_EN])
      begin
        cfgNxt.counterEn = 1'b1;
        cfgNxt.intEn     = 1'b1;
        if (state_r == wdt_pkg::ST_OFF)
        begin
          stateNxt = wdt_pkg::ST_RUN;
          countNxt = loadWr ? loadMrg : load_r;
        end
      end
      if (wbDatWr[wdt_pkg::CB_INTEN])
      begin
        cfgNxt.intEn = 1'b1;
      end
      cfgNxt.resetEn = wbDatWr[wdt_pkg::CB_RSTEN];
      cfgNxt.stallEn = wbDatWr[wdt_pkg::CB_STALL];
    end

    // Key unlocks, any other value locks
    if (wr && wbAdr == wdt_pkg::OFS_LOCK)
    begin
      lockNxt = (wbDatWr != wdt_pkg::UNLOCK_KEY);
    end

    // A set in the same cycle as a clear wins
    intRawNxt = intSet | (intRaw_r & ~intClr);
    irqNxt    = intRawNxt & cfgNxt.intEn;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and acknowledge

  // Unmapped addresses answer with zero so the master never hangs
  always_comb
  begin
    ackNxt = access;
    datNxt = wdt_pkg::DATA_ZERO;
    if (access && !wbWe)
    begin
      if (wbAdr == wdt_pkg::OFS_LOAD)
      begin
        datNxt = load_r;
      end
      else if (wbAdr == wdt_pkg::OFS_VALUE)
      begin
        datNxt = count_r;
      end
      else if (wbAdr == wdt_pkg::OFS_CTRL)
      begin
        datNxt[wdt_pkg::CB_EN]    = cfg_r.counterEn;
        datNxt[wdt_pkg::CB_INTEN] = cfg_r.intEn;
        datNxt[wdt_pkg::CB_RSTEN] = cfg_r.resetEn;
        datNxt[wdt_pkg::CB_STALL] = cfg_r.stallEn;
      end
      else if (wbAdr == wdt_pkg::OFS_RIS)
      begin
        datNxt[wdt_pkg::SB_INT] = intRaw_r;
      end
      else if (wbAdr == wdt_pkg::OFS_MIS)
      begin
        datNxt[wdt_pkg::SB_INT] = intRaw_r & cfg_r.intEn;
      end
      else if (wbAdr == wdt_pkg::OFS_LOCK)
      begin
        datNxt[wdt_pkg::SB_LOCK] = lock_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Every output comes from here; reset returns disabled and unlocked
  always_ff @(posedge clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      count_r     <= wdt_pkg::LOAD_RST;
      load_r      <= wdt_pkg::LOAD_RST;
      cfg_r       <= wdt_pkg::CFG_RST;
      state_r     <= wdt_pkg::ST_OFF;
      intRaw_r    <= 1'b0;
      lock_r      <= 1'b0;
      wbAck       <= 1'b0;
      wbDatRd     <= wdt_pkg::DATA_ZERO;
      irq         <= 1'b0;
      sysResetOut <= 1'b0;
    end
    else
    begin
      count_r     <= countNxt;
      load_r      <= loadNxt;
      cfg_r       <= cfgNxt;
      state_r     <= stateNxt;
      intRaw_r    <= intRawNxt;
      lock_r      <= lockNxt;
      wbAck       <= ackNxt;
      wbDatRd     <= datNxt;
      irq         <= irqNxt;
      sysResetOut <= resetNxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!rstSync_b);

  // Steps of the second timeout
  sequence secondTimeout;
    timeout && intRaw_r && cfg_r.resetEn;
  endsequence

  sequence resetRaised;
    (state_r == wdt_pkg::ST_RESET) ##1 sysResetOut;
  endsequence

  locked_load_a: assert property (
    lock_r && wr && wbAdr == wdt_pkg::OFS_LOAD |=> $stable(load_r))
    else $error("load changed while locked");

  locked_cfg_a: assert property (
    lock_r && wr && wbAdr == wdt_pkg::OFS_CTRL |=> $stable(cfg_r))
    else $error("configuration changed while locked");

  first_timeout_a: assert property (
    timeout && !intRaw_r |=> intRaw_r && (irq == cfg_r.intEn))
    else $error("first timeout did not raise interrupt");

  enable_arms_a: assert property (
    $rose(cfg_r.counterEn) |-> cfg_r.intEn && state_r == wdt_pkg::ST_RUN)
    else $error("enable did not arm interrupt");

  timeout_reload_a: assert property (
    timeout && !loadWr |=> count_r == $past(load_r))
    else $error("counter not reloaded after timeout");

  second_reset_a: assert property (
    secondTimeout |=> resetRaised)
    else $error("second timeout did not assert reset");

  clear_reload_a: assert property (
    intClr && !timeout && !loadWr && state_r == wdt_pkg::ST_RUN
    |=> !intRaw_r && count_r == $past(load_r))
    else $error("clear did not reload counter");

  load_running_a: assert property (
    loadWr && state_r == wdt_pkg::ST_RUN |=> count_r == load_r)
    else $error("running counter not loaded");

  zero_load_a: assert property (
    loadWr && loadMrg == wdt_pkg::CNT_ZERO |=> intRaw_r)
    else $error("zero load gave no interrupt");

  stall_hold_a: assert property (
    state_r == wdt_pkg::ST_RUN && halted && !wr |=> $stable(count_r))
    else $error("counter moved while stalled");

  reset_sticky_a: assert property (
    sysResetOut |=> sysResetOut)
    else $error("reset output dropped");

  enable_sticky_a: assert property (
    cfg_r.counterEn |=> cfg_r.counterEn)
    else $error("counter enable dropped");

endmodule : two_stage_watchdog_timer

//--- verilog/wdt_pkg.sv
// Shared constants, types and register map of the two-stage watchdog
package wdt_pkg;

  // Data path widths
  localparam int CNT_W = 32;
  localparam int ADR_W = 8;
  localparam int SEL_W = 4;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] OFS_LOAD   = 8'h00;
  localparam logic [7:0] OFS_VALUE  = 8'h04;
  localparam logic [7:0] OFS_CTRL   = 8'h08;
  localparam logic [7:0] OFS_INTCLR = 8'h0C;
  localparam logic [7:0] OFS_RIS    = 8'h10;
  localparam logic [7:0] OFS_MIS    = 8'h14;
  localparam logic [7:0] OFS_LOCK   = 8'h18;

  // Control register field positions
  localparam int CB_EN    = 0;
  localparam int CB_INTEN = 1;
  localparam int CB_RSTEN = 2;
  localparam int CB_STALL = 3;

  // Status and lock field positions
  localparam int SB_INT  = 0;
  localparam int SB_LOCK = 0;

  // Reset values and special codes
  localparam logic [31:0] LOAD_RST   = 32'hFFFF_FFFF;
  localparam logic [31:0] CNT_ZERO   = 32'h0000_0000;
  localparam logic [31:0] CNT_ONE    = 32'h0000_0001;
  localparam logic [31:0] DATA_ZERO  = 32'h0000_0000;
  // Unlock key; the value is arbitrary
  localparam logic [31:0] UNLOCK_KEY = 32'h5A5A_A5A5;

  // Configuration held by the block
  typedef struct packed {
    logic stallEn;
    logic resetEn;
    logic intEn;
    logic counterEn;
  } cfg_t;

  localparam cfg_t CFG_RST = '{stallEn: 1'b0, resetEn: 1'b0, intEn: 1'b0, counterEn: 1'b0};

  // Run state of the counter
  typedef enum logic [1:0] {
    ST_OFF,
    ST_RUN,
    ST_RESET
  } state_t;

endpackage : wdt_pkg

//--- verilog/wdt_rst_sync.sv
// Reset synchroniser: asynchronous assert, release through two flip-flops
`timescale 1ns/1ps
module wdt_rst_sync
(
  input  wire logic clk,       // System clock
  input  wire logic rst_b,     // Raw reset, active low
  output logic      rstSync_b  // Synchronised reset, active low
);

  logic stage1_r;

  // First stage takes a constant, second takes the first; release walks through two edges
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage1_r  <= 1'b0;
      rstSync_b <= 1'b0;
    end
    else
    begin
      stage1_r  <= 1'b1;
      rstSync_b <= stage1_r;
    end
  end

endmodule : wdt_rst_sync

//--- verilog/wdt_sync2.sv
// Two flip-flop level synchroniser for an asynchronous pin
`timescale 1ns/1ps
module wdt_sync2
(
  input  wire logic clk,      // System clock
  input  wire logic rst_b,    // Synchronised reset, active low
  input  wire logic asyncIn,  // Pin from outside the clock domain
  output logic      syncOut   // Level safe to use in clk domain
);

  logic meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_r  <= 1'b0;
      syncOut <= 1'b0;
    end
    else
    begin
      meta_r  <= asyncIn;
      syncOut <= meta_r;
    end
  end

endmodule : wdt_sync2

//--- verif/two_stage_watchdog_timer_tb_top.sv
// Self-checking bench for the two-stage watchdog over its Wishbone port
`timescale 1ns/1ps
module two_stage_watchdog_timer_tb_top;

  logic        clk;         // Bench clock
  logic        rst_b;       // Reset, active low
  logic        wbCyc;       // Wishbone cycle
  logic        wbStb;       // Wishbone strobe
  logic        wbWe;        // Write enable
  logic [3:0]  wbSel;       // Byte lanes
  logic [7:0]  wbAdr;       // Byte address
  logic [31:0] wbDatWr;     // Write data
  logic [31:0] wbDatRd;     // Read data
  logic        wbAck;       // Acknowledge
  logic        dbgHalt;     // Debug halt pin
  logic        irq;         // Masked interrupt
  logic        sysResetOut; // Reset request
  logic [31:0] rdA;         // Read scratch
  logic [31:0] rdB;         // Read scratch
  int          fails;       // Mismatches
  int          check_count; // Comparisons made

  two_stage_watchdog_timer two_stage_watchdog_timer_inst
  (
    .clk         (clk),
    .rst_b       (rst_b),
    .wbCyc       (wbCyc),
    .wbStb       (wbStb),
    .wbWe        (wbWe),
    .wbSel       (wbSel),
    .wbAdr       (wbAdr),
    .wbDatWr     (wbDatWr),
    .wbDatRd     (wbDatRd),
    .wbAck       (wbAck),
    .dbgHalt     (dbgHalt),
    .irq         (irq),
    .sysResetOut (sysResetOut)
  );

  ////////////////////////////////////////////////////////////////////////
  // 250 MHz clock
  always #2 clk = ~clk;

  // Print the verdict and stop
  task results;
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  // Compare two words, four-state exact
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////
  // One classic cycle; waits for ack without assuming its latency
  task wbXfer(input logic we, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    wbCyc   <= 1'b1;
    wbStb   <= 1'b1;
    wbWe    <= we;
    wbAdr   <= a;
    wbDatWr <= d;
    wbSel   <= 4'hF;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wbAck !== 1'b1 && n < 50);
    q = wbDatRd;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
    chk("wbAck", 32'h1, {31'h0, wbAck});
  endtask : wbXfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wbXfer(1'b1, a, d, q);
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] q);
    wbXfer(1'b0, a, 32'h0, q);
  endtask : rd

  // Read a register and compare it
  task rdChk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    rd(a, q);
    chk(nm, exp, q);
  endtask : rdChk

  // Wait bounded for irq (sel 0) or sysResetOut (sel 1) to be high
  task waitHi(input bit sel, input int lim);
    int n;
    n = 0;
    while ((sel ? sysResetOut : irq) !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    if (sel)
      chk("sysResetOut", 32'h1, {31'h0, sysResetOut});
    else
      chk("irq", 32'h1, {31'h0, irq});
  endtask : waitHi

  ////////////////////////////////////////////////////////////////////////
  // Watchdog sized well above the expected run length
  initial
  begin
    #80000;
    fails++;
    results();
  end

  // Main sequence
  initial
  begin
    clk = 1'b0; rst_b = 1'b0; wbCyc = 1'b0; wbStb = 1'b0; wbWe = 1'b0;
    wbSel = 4'h0; wbAdr = 8'h00; wbDatWr = 32'h0; dbgHalt = 1'b0;
    fails = 0; check_count = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset state and an unmapped address
    rdChk("load", wdt_pkg::OFS_LOAD, 32'hFFFF_FFFF);
    rdChk("value", wdt_pkg::OFS_VALUE, 32'hFFFF_FFFF);
    rdChk("ris", wdt_pkg::OFS_RIS, 32'h0);
    rdChk("lock", wdt_pkg::OFS_LOCK, 32'h0);
    rdChk("unmapped", 8'h40, 32'h0);
    // Zero load while disabled: raw status only, masked output stays low
    wr(wdt_pkg::OFS_LOAD, 32'h0);
    rdChk("risOff", wdt_pkg::OFS_RIS, 32'h1);
    rdChk("misOff", wdt_pkg::OFS_MIS, 32'h0);
    chk("irqOff", 32'h0, {31'h0, irq});
    wr(wdt_pkg::OFS_INTCLR, 32'h0);
    rdChk("risOffClr", wdt_pkg::OFS_RIS, 32'h0);
    // Enable alone must arm the interrupt path too
    wr(wdt_pkg::OFS_LOAD, 32'h0000_1000);
    rdChk("load", wdt_pkg::OFS_LOAD, 32'h0000_1000);
    wr(wdt_pkg::OFS_CTRL, 32'h0000_0001);
    rd(wdt_pkg::OFS_VALUE, rdA);
    rd(wdt_pkg::OFS_VALUE, rdB);
    chk("countDown", 32'h1, {31'h0, rdB < rdA && rdA <= 32'h1000});
    wr(wdt_pkg::OFS_LOAD, 32'h0000_0014);
    rd(wdt_pkg::OFS_VALUE, rdA);
    chk("loadNow", 32'h1, {31'h0, rdA <= 32'h14});
    waitHi(1'b0, 40);
    rdChk("ris", wdt_pkg::OFS_RIS, 32'h1);
    rdChk("mis", wdt_pkg::OFS_MIS, 32'h1);
    wr(wdt_pkg::OFS_INTCLR, 32'h0);
    rdChk("risClr", wdt_pkg::OFS_RIS, 32'h0);
    rd(wdt_pkg::OFS_VALUE, rdA);
    // Without the reload the count would already be near 6 here
    chk("reload", 32'h1, {31'h0, rdA >= 32'h0C && rdA <= 32'h14});
    // Locked: configuration writes dropped, reset enable too
    wr(wdt_pkg::OFS_LOCK, 32'h0);
    rdChk("lock", wdt_pkg::OFS_LOCK, 32'h1);
    wr(wdt_pkg::OFS_LOAD, 32'h0000_0500);
    rdChk("loadLocked", wdt_pkg::OFS_LOAD, 32'h0000_0014);
    wr(wdt_pkg::OFS_CTRL, 32'h0000_0004);
    wr(wdt_pkg::OFS_CTRL, 32'h0);
    rdChk("ctrlLocked", wdt_pkg::OFS_CTRL, 32'h0000_0003);
    waitHi(1'b0, 40);
    repeat (60) @(posedge clk);
    chk("noReset", 32'h0, {31'h0, sysResetOut});
    wr(wdt_pkg::OFS_LOCK, wdt_pkg::UNLOCK_KEY);
    rdChk("unlock", wdt_pkg::OFS_LOCK, 32'h0);
    wr(wdt_pkg::OFS_INTCLR, 32'h0);
    // Debug halt freezes the count when stalling is on
    wr(wdt_pkg::OFS_CTRL, 32'h0000_0008);
    rdChk("ctrl", wdt_pkg::OFS_CTRL, 32'h0000_000B);
    dbgHalt <= 1'b1;
    repeat (4) @(posedge clk);
    rd(wdt_pkg::OFS_VALUE, rdA);
    repeat (5) @(posedge clk);
    rd(wdt_pkg::OFS_VALUE, rdB);
    chk("stall", rdA, rdB);
    dbgHalt <= 1'b0;
    // Zero load raises the interrupt at once
    wr(wdt_pkg::OFS_LOAD, 32'h0);
    waitHi(1'b0, 4);
    wr(wdt_pkg::OFS_LOAD, 32'h0000_001E);
    wr(wdt_pkg::OFS_INTCLR, 32'h0);
    // Second timeout with reset enabled; request is sticky
    wr(wdt_pkg::OFS_CTRL, 32'h0000_0004);
    waitHi(1'b0, 40);
    waitHi(1'b1, 40);
    wr(wdt_pkg::OFS_INTCLR, 32'h0);
    repeat (10) @(posedge clk);
    chk("sticky", 32'h1, {31'h0, sysResetOut});
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    chk("rstClear", 32'h0, {31'h0, sysResetOut});
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rdChk("loadRst", wdt_pkg::OFS_LOAD, 32'hFFFF_FFFF);
    rdChk("lockRst", wdt_pkg::OFS_LOCK, 32'h0);
    rdChk("ctrlRst", wdt_pkg::OFS_CTRL, 32'h0);
    results();
  end

endmodule : two_stage_watchdog_timer_tb_top
